/* File: rtl/rimc_master_config.sv */
// Purpose: Configuration latch, supervision and timing of a remote I/O bus master.
// Assumes: All inputs synchronous to clock; selector and switches held still in operation.
// Notes: AXI4-Lite slave for restart, interrupts and the registration table.
// Behaviour
// (R1) Unit number valid 0..95 in narrow range, 0..94 in wide range.
// (R2) Unit number selects the host I/O words and data-memory words.
// (R3) Narrow range: nodes 0-7 each way, 10 words: 4 in, 4 out, 2 status.
// (R4) Wide range: nodes 0-15 each way, 20 words: 8 in, 8 out, 4 status.
// (R5) Wide range occupies own unit block and the next; others must not use them.
// (R6) Duplicate unit number is flagged by host; system does not start.
// (R7) Unit number defaults to 00.
// (R8) All four switches default to off.
// (R9) Operator powers down before changing switches.
// (R10) Rate select: 750 kbps off, 93.75 kbps on.
// (R11) Cycle time 0.5/0.8 ms fast, 4.0/6.0 ms long, by node range.
// (R12) Mismatched slave fails alone; master link indicator stays normal.
// (R13) Stop-on-error off keeps exchanging; on halts exchange on error.
// (R14) Halted exchange resumes only after power cycle or unit restart.
// (R15) Registration on: flag registered slaves joined and unregistered slaves present.
// (R16) Host loads registration tables before relying on registration.
// (R17) Device takes 100 data-memory words regardless of node range.
// (R18) Unit number and switches latched once at power-up or restart.
// (R19) Out-of-range unit number is a configuration error; no exchange starts.
`timescale 1ns/1ps
`default_nettype none
module rimc_master_config #(
  parameter int unsigned CYC_FAST_NARROW = rimc_pkg::CYC_FAST_NARROW,
  parameter int unsigned CYC_FAST_WIDE = rimc_pkg::CYC_FAST_WIDE,
  parameter int unsigned CYC_LONG_NARROW = rimc_pkg::CYC_LONG_NARROW,
  parameter int unsigned CYC_LONG_WIDE = rimc_pkg::CYC_LONG_WIDE
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Unit selector and configuration switches
  input wire logic [3:0] unit_tens,
  input wire logic [3:0] unit_ones,
  input wire logic node_range_select,
  input wire logic rate_mode_select,
  input wire logic stop_on_error_select,
  input wire logic registration_enable,
  // Host and bus engine status
  input wire logic host_unit_overlap,
  input wire logic link_ok_indicator_error,
  input wire logic [31:0] slave_present,
  // Exchange control and allocation
  output logic exchange_active,
  output logic cycle_start,
  output logic bit_tick,
  output logic link_ok_indicator,
  output logic [31:0] node_enable,
  output rimc_pkg::rimc_alloc_t alloc,
  output rimc_pkg::rimc_cfg_t cfg,
  output logic irq,
  // AXI4-Lite slave
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Merge written bytes into a register
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = new_val[8*i +: 8];
    end
    return res;
  endfunction

  // Register offsets this slave answers
  function automatic logic is_mapped(input logic [7:0] addr);
    return addr[7:5] == 3'h0 && addr[1:0] == 2'h0;
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rimc_pkg::rimc_state_t state;
  rimc_pkg::rimc_state_t next_state;
  logic [6:0] unit_num;
  logic [6:0] unit_sel;
  logic unit_bad;
  logic restart;
  logic [rimc_pkg::IRQ_BITS-1:0] irq_status;
  logic [rimc_pkg::IRQ_BITS-1:0] irq_mask;
  logic [rimc_pkg::IRQ_BITS-1:0] irq_set;
  logic [rimc_pkg::IRQ_BITS-1:0] irq_clr;
  logic [31:0] reg_table;
  logic [31:0] joined;
  logic [17:0] cyc_cnt;
  logic [17:0] cyc_len;
  logic [8:0] bit_cnt;
  logic [8:0] bit_len;
  logic last_cycle_err;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;

  // Selector digits to binary; a digit above nine is out of range anyway
  assign unit_sel = 7'(unit_tens) * 7'h0A + 7'(unit_ones);

  // ----------------------------------------
  // Configuration latch and sequencing
  // ----------------------------------------
  // Latch once on leaving idle or on restart; later switch moves are ignored
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      unit_num <= rimc_pkg::UNIT_DEFAULT; // see (R7)
      cfg <= rimc_pkg::CFG_RESET; // see (R8)
    end
    else if (state == rimc_pkg::ST_LATCH)
    begin
      unit_num <= unit_sel; // see (R18)
      cfg <= '{node_range_select, rate_mode_select, stop_on_error_select,
               registration_enable};
    end
  end

  // Range check depends on the node range width
  assign unit_bad = unit_tens > 4'h9 || unit_ones > 4'h9 ||
                    unit_num > (cfg.node_wide ? rimc_pkg::UNIT_MAX_WIDE
                                              : rimc_pkg::UNIT_MAX_NARROW); // see (R1)

  // Exchange state sequence
  always_comb
  begin
    next_state = state;
    case (state)
      rimc_pkg::ST_IDLE: next_state = rimc_pkg::ST_LATCH;
      rimc_pkg::ST_LATCH: next_state = rimc_pkg::ST_CHECK;
      rimc_pkg::ST_CHECK:
        // Bad number or a clash on the host leaves the bus silent
        if (unit_bad || host_unit_overlap) // see (R19) (R6) (R5)
          next_state = rimc_pkg::ST_CFGERR;
        else
          next_state = rimc_pkg::ST_RUN;
      rimc_pkg::ST_RUN:
        if (link_ok_indicator_error && cfg.stop_on_error) // see (R13)
          next_state = rimc_pkg::ST_HALT;
      rimc_pkg::ST_HALT: next_state = rimc_pkg::ST_HALT; // see (R14)
      rimc_pkg::ST_CFGERR: next_state = rimc_pkg::ST_CFGERR;
      default: next_state = rimc_pkg::ST_IDLE;
    endcase
    // Restart re-latches the selector, which power-down changes may have moved
    if (restart) // see (R14) (R9)
      next_state = rimc_pkg::ST_LATCH;
  end

  // State register
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state <= rimc_pkg::ST_IDLE;
    else
      state <= next_state;
  end

  assign exchange_active = state == rimc_pkg::ST_RUN;

  // ----------------------------------------
  // Host word allocation
  // ----------------------------------------
  // Wide range takes this unit's block and the next one
  always_comb
  begin
    alloc.io_offset = 10'(unit_num) * 10'(rimc_pkg::WORDS_PER_UNIT); // see (R2)
    alloc.io_count = cfg.node_wide ? 5'(2 * rimc_pkg::WORDS_PER_UNIT)
                                   : 5'(rimc_pkg::WORDS_PER_UNIT); // see (R3) (R4) (R5)
    alloc.in_words = cfg.node_wide ? 4'(2 * rimc_pkg::IN_WORDS_NARROW)
                                   : rimc_pkg::IN_WORDS_NARROW;
    alloc.out_words = cfg.node_wide ? 4'(2 * rimc_pkg::OUT_WORDS_NARROW)
                                    : rimc_pkg::OUT_WORDS_NARROW;
    alloc.stat_words = cfg.node_wide ? 4'(2 * rimc_pkg::STAT_WORDS_NARROW)
                                     : rimc_pkg::STAT_WORDS_NARROW;
    alloc.dm_offset = 14'(unit_num) * 14'(rimc_pkg::DM_WORDS); // see (R17)
    alloc.dm_count = rimc_pkg::DM_WORDS;
  end

  // Input nodes in low half, output nodes in high half
  assign node_enable = cfg.node_wide ? rimc_pkg::NODE_MASK_WIDE
                                     : rimc_pkg::NODE_MASK_NARROW; // see (R3) (R4)

  // ----------------------------------------
  // Bit rate and cycle timing
  // ----------------------------------------
  assign bit_len = cfg.rate_long ? 9'(rimc_pkg::LONG_BIT_CYCLES)
                                 : 9'(rimc_pkg::FAST_BIT_CYCLES); // see (R10)
  assign cyc_len = cfg.rate_long ? (cfg.node_wide ? 18'(CYC_LONG_WIDE) : 18'(CYC_LONG_NARROW))
                                 : (cfg.node_wide ? 18'(CYC_FAST_WIDE)
                                                  : 18'(CYC_FAST_NARROW)); // see (R11)

  // Both counters run only while exchanging, so a halt freezes the bus
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt <= 9'h000;
      cyc_cnt <= 18'h00000;
      bit_tick <= 1'b0;
      cycle_start <= 1'b0;
    end
    else if (!exchange_active)
    begin
      bit_cnt <= 9'h000;
      cyc_cnt <= 18'h00000;
      bit_tick <= 1'b0;
      cycle_start <= 1'b0;
    end
    else
    begin
      bit_tick <= bit_cnt == 9'h000;
      bit_cnt <= bit_cnt == bit_len - 9'h001 ? 9'h000 : bit_cnt + 9'h001;
      cycle_start <= cyc_cnt == 18'h00000;
      cyc_cnt <= cyc_cnt == cyc_len - 18'h00001 ? 18'h00000 : cyc_cnt + 18'h00001;
    end
  end

  // Indicator follows master errors only; one slave on the wrong rate does not drop it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      last_cycle_err <= 1'b0;
    else if (!exchange_active || cycle_start)
      last_cycle_err <= link_ok_indicator_error;
    else if (link_ok_indicator_error)
      last_cycle_err <= 1'b1;
  end
  assign link_ok_indicator = exchange_active && !last_cycle_err; // see (R12)

  // ----------------------------------------
  // Slave registration monitor
  // ----------------------------------------
  // Compared once per cycle against the table the host has loaded
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      joined <= 32'h0000_0000;
    else if (exchange_active && cycle_start && cfg.reg_enable)
      joined <= slave_present & reg_table & node_enable; // see (R15) (R16)
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb
  begin
    irq_set = '0;
    irq_set[rimc_pkg::IRQ_LINK_OK_INDICATOR_ERR] = exchange_active && link_ok_indicator_error;
    irq_set[rimc_pkg::IRQ_HALTED] = exchange_active && link_ok_indicator_error && cfg.stop_on_error;
    irq_set[rimc_pkg::IRQ_UNREG] = exchange_active && cycle_start && cfg.reg_enable &&
                                   |(slave_present & ~reg_table & node_enable); // see (R15)
    irq_set[rimc_pkg::IRQ_MISSING] = exchange_active && cycle_start && cfg.reg_enable &&
                                     |(reg_table & node_enable & ~slave_present);
    irq_set[rimc_pkg::IRQ_CFG_ERR] = state == rimc_pkg::ST_CHECK &&
                                     (unit_bad || host_unit_overlap); // see (R19)
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      irq_status <= '0;
    else
      irq_status <= (irq_status & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;

  // Address and data taken in either order, answered once both are held
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rimc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_addr) ? rimc_pkg::RESP_OKAY : rimc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Write side effects
  assign restart = wr_fire && aw_addr == rimc_pkg::OFS_CONTROL && w_strb[0] &&
                   w_data[rimc_pkg::BIT_RESTART];
  assign irq_clr = (wr_fire && aw_addr == rimc_pkg::OFS_IRQ_STATUS && w_strb[0]) ?
                   w_data[rimc_pkg::IRQ_BITS-1:0] : '0;

  // Software written registers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irq_mask <= rimc_pkg::IRQ_MASK_RESET;
      reg_table <= rimc_pkg::REG_TABLE_RESET;
    end
    else if (wr_fire)
    begin
      if (aw_addr == rimc_pkg::OFS_IRQ_MASK)
        irq_mask <= rimc_pkg::IRQ_BITS'(merge_bytes(32'(irq_mask), w_data, w_strb));
      if (aw_addr == rimc_pkg::OFS_REG_TABLE)
        reg_table <= merge_bytes(reg_table, w_data, w_strb); // see (R16)
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  // Read data registered; one cycle after the address is taken
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= rimc_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? rimc_pkg::RESP_OKAY : rimc_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        rimc_pkg::OFS_STATE: s_axi_rdata <= {17'h00000, unit_num, cfg, 1'b0, state};
        rimc_pkg::OFS_IRQ_STATUS: s_axi_rdata <= 32'(irq_status);
        rimc_pkg::OFS_IRQ_MASK: s_axi_rdata <= 32'(irq_mask);
        rimc_pkg::OFS_REG_TABLE: s_axi_rdata <= reg_table;
        rimc_pkg::OFS_JOINED: s_axi_rdata <= joined;
        rimc_pkg::OFS_IO_ALLOC: s_axi_rdata <= {1'b0, alloc.stat_words, alloc.out_words,
                                                alloc.in_words, 4'h0, alloc.io_count,
                                                alloc.io_offset};
        rimc_pkg::OFS_DM_ALLOC: s_axi_rdata <= {11'h000, alloc.dm_count, alloc.dm_offset};
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // Gap between bit ticks, helper for the rate check
  logic [8:0] gap_cnt;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gap_cnt <= 9'h000;
    else if (bit_tick || !exchange_active)
      gap_cnt <= 9'h001;
    else
      gap_cnt <= gap_cnt + 9'h001;
  end

  sequence s_err_in_stop;
    state == rimc_pkg::ST_RUN && cfg.stop_on_error && link_ok_indicator_error && !restart;
  endsequence
  sequence s_halted_held;
    state == rimc_pkg::ST_HALT [*3];
  endsequence

  a_halt_on_error: assert property (s_err_in_stop |=> state == rimc_pkg::ST_HALT) // see (R13)
    else $error("exchange did not halt on error");
  a_keep_running: assert property (state == rimc_pkg::ST_RUN && !cfg.stop_on_error &&
    link_ok_indicator_error && !restart |=> state == rimc_pkg::ST_RUN) // see (R13)
    else $error("exchange stopped with stop mode off");
  a_halt_sticky: assert property (s_err_in_stop ##1 !restart [*2] |-> ##[0:1] s_halted_held) // see (R14)
    else $error("halted exchange resumed without restart");
  a_range_error: assert property (state == rimc_pkg::ST_CHECK && unit_bad
    |=> state == rimc_pkg::ST_CFGERR && !exchange_active) // see (R19)
    else $error("out of range unit started exchange");
  a_cfg_frozen: assert property (state == rimc_pkg::ST_RUN |-> ##1 $stable(cfg) && $stable(unit_num)) // see (R18)
    else $error("configuration changed during operation");
  a_word_count: assert property (exchange_active |-> alloc.io_count == (cfg.node_wide ? 5'h14 : 5'h0A)
    && alloc.in_words + alloc.out_words + alloc.stat_words == 4'(alloc.io_count)) // see (R3) (R4)
    else $error("host word count wrong for node range");
  a_dm_alloc: assert property (alloc.dm_count == 7'h64 && alloc.dm_offset == 14'(unit_num) * 14'h0064
    && alloc.io_offset == 10'(unit_num) * 10'h00A) // see (R17) (R2)
    else $error("host allocation does not follow unit number");
  a_bit_rate: assert property (exchange_active && bit_tick && $past(exchange_active, 2) && $past(bit_tick, 1) == 1'b0
    |-> gap_cnt == (cfg.rate_long ? 9'h1AA : 9'h035)) // see (R10)
    else $error("bit period wrong for rate mode");
  a_unreg_flag: assert property (exchange_active && cycle_start && cfg.reg_enable &&
    |(slave_present & ~reg_table & node_enable) |=> irq_status[rimc_pkg::IRQ_UNREG]) // see (R15)
    else $error("unregistered slave not flagged");
  a_irq_level: assert property (irq == |(irq_status & irq_mask))
    else $error("interrupt output disagrees with status and mask");
endmodule
`default_nettype wire

/* File: rtl/rimc_pkg.sv */
// Purpose: Shared constants and types of the remote I/O master configuration block.
// Assumes: 40 MHz system clock; AXI4-Lite register access with 32-bit data.
// Notes: Timing counts are derived here and reused as top-level parameter defaults.
package rimc_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLOCK_HZ = 40_000_000;
  localparam int unsigned CLOCK_NS = 25;
  localparam int unsigned FAST_BPS = 750_000;
  localparam longint unsigned LONG_BPS_X100 = 9_375_000;
  localparam int unsigned FAST_BIT_CYCLES = CLOCK_HZ / FAST_BPS;
  localparam int unsigned LONG_BIT_CYCLES =
    int'((longint'(CLOCK_HZ) * 64'd100) / LONG_BPS_X100);
  localparam int unsigned CYC_FAST_NARROW_US = 500;
  localparam int unsigned CYC_FAST_WIDE_US = 800;
  localparam int unsigned CYC_LONG_NARROW_US = 4000;
  localparam int unsigned CYC_LONG_WIDE_US = 6000;
  localparam int unsigned CYC_FAST_NARROW = CYC_FAST_NARROW_US * 1000 / CLOCK_NS;
  localparam int unsigned CYC_FAST_WIDE = CYC_FAST_WIDE_US * 1000 / CLOCK_NS;
  localparam int unsigned CYC_LONG_NARROW = CYC_LONG_NARROW_US * 1000 / CLOCK_NS;
  localparam int unsigned CYC_LONG_WIDE = CYC_LONG_WIDE_US * 1000 / CLOCK_NS;
  // ----------------------------------------
  // Unit number and host word allocation
  // ----------------------------------------
  localparam logic [6:0] UNIT_MAX_NARROW = 7'h5F;
  localparam logic [6:0] UNIT_MAX_WIDE = 7'h5E;
  localparam logic [6:0] UNIT_DEFAULT = 7'h00;
  localparam logic [3:0] WORDS_PER_UNIT = 4'hA;
  localparam logic [6:0] DM_WORDS = 7'h64;
  localparam logic [3:0] IN_WORDS_NARROW = 4'h4;
  localparam logic [3:0] OUT_WORDS_NARROW = 4'h4;
  localparam logic [3:0] STAT_WORDS_NARROW = 4'h2;
  localparam logic [31:0] NODE_MASK_NARROW = 32'h00FF_00FF;
  localparam logic [31:0] NODE_MASK_WIDE = 32'hFFFF_FFFF;
  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_REG_TABLE = 8'h10;
  localparam logic [7:0] OFS_JOINED = 8'h14;
  localparam logic [7:0] OFS_IO_ALLOC = 8'h18;
  localparam logic [7:0] OFS_DM_ALLOC = 8'h1C;
  localparam int BIT_RESTART = 0;
  localparam int IRQ_LINK_OK_INDICATOR_ERR = 0;
  localparam int IRQ_HALTED = 1;
  localparam int IRQ_UNREG = 2;
  localparam int IRQ_MISSING = 3;
  localparam int IRQ_CFG_ERR = 4;
  localparam int IRQ_BITS = 5;
  localparam logic [IRQ_BITS-1:0] IRQ_MASK_RESET = 5'h00;
  localparam logic [31:0] REG_TABLE_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Configuration switches as latched
  typedef struct packed {
    logic node_wide;
    logic rate_long;
    logic stop_on_error;
    logic reg_enable;
  } rimc_cfg_t;
  localparam rimc_cfg_t CFG_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

  // Host word allocation
  typedef struct packed {
    logic [9:0] io_offset;
    logic [4:0] io_count;
    logic [3:0] in_words;
    logic [3:0] out_words;
    logic [3:0] stat_words;
    logic [13:0] dm_offset;
    logic [6:0] dm_count;
  } rimc_alloc_t;

  // Gray coded along idle, latch, check, run, halt
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LATCH = 3'h1,
    ST_CHECK = 3'h3,
    ST_RUN = 3'h2,
    ST_HALT = 3'h6,
    ST_CFGERR = 3'h7
  } rimc_state_t;
endpackage

/* File: testbench/rimc_master_config_test.sv */
// Purpose: Self-checking bench of the remote I/O master configuration block.
// Assumes: Short cycle counts set through the top parameters.
// Notes: Checks land 1 ns after an edge so that register updates settle.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    #1; \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      err_total++; \
      $display("wrong value %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module rimc_master_config_test;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [3:0] tens = 4'h1, ones = 4'h2, sw = 4'h0;
  logic ovl = 1'h0, fault = 1'h0, cerr, act, cst, btk, irq, lok;
  logic [31:0] present, node_en, wd = 32'h0, rdat, rd;
  rimc_pkg::rimc_alloc_t alloc;
  rimc_pkg::rimc_cfg_t cfg;
  logic awv = 1'h0, awr, wv = 1'h0, wr_r, bv, br = 1'h0, arv = 1'h0, arr, rv, rr = 1'h0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [1:0] bresp, rresp, resp;
  int err_total = 0;
  int comparisons = 0;
  rimc_master_config #(.CYC_FAST_NARROW(200), .CYC_FAST_WIDE(320), .CYC_LONG_NARROW(1600),
    .CYC_LONG_WIDE(2400)) i_rimc_master_config (.clock, .rst, .unit_tens(tens),
    .unit_ones(ones), .node_range_select(sw[3]), .rate_mode_select(sw[2]),
    .stop_on_error_select(sw[1]), .registration_enable(sw[0]), .host_unit_overlap(ovl),
    .link_ok_indicator_error(cerr), .slave_present(present), .exchange_active(act), .cycle_start(cst),
    .bit_tick(btk), .link_ok_indicator(lok), .node_enable(node_en), .alloc, .cfg, .irq,
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp));
  rimc_slave_chain i_rimc_slave_chain (.fault_req(fault), .link_ok_indicator_error(cerr),
    .slave_present(present));
  // Free-running 40 MHz clock
  always #12.5 clock = ~clock;
  // One AXI4-Lite write or read; each channel held until the rising edge that takes it
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic ans;
    ans = 1'h0;
    @(posedge clock);
    awv <= w;
    wv <= w;
    awa <= a;
    wd <= d;
    br <= w;
    arv <= !w;
    ara <= a;
    rr <= !w;
    // No local limit: only the watchdog ends a wait for the answer
    while (!ans)
    begin
      @(posedge clock);
      ans = w ? bv : rv;
      resp = w ? bresp : rresp;
      rd = rdat;
      if (awv && awr) awv <= 1'h0;
      if (wv && wr_r) wv <= 1'h0;
      if (arv && arr) arv <= 1'h0;
    end
    br <= 1'h0;
    rr <= 1'h0;
  endtask
  // Unit restart, then time for latch and check
  task automatic restart();
    xfer(1'h1, 8'h00, 32'h1);
    repeat (6) @(posedge clock);
  endtask
  // Period between two pulses of cycle start or bit tick
  task automatic span(input logic bt, input int exp);
    int n = 0;
    int k = 0;
    while (k < 2)
    begin
      @(negedge clock);
      if (k > 0) n++;
      if (bt ? btk : cst) k++;
    end
    `CHK("period", exp, n)
  endtask
  // One error cycle reported by the slave side
  task automatic pulse_fault();
    @(posedge clock);
    fault <= 1'h1;
    @(posedge clock);
    fault <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run of some 7000 cycles
  initial
  begin
    #(25 * 40000);
    err_total++;
    print_verdict();
  end
  // Test sequence
  initial
  begin
    repeat (12) @(posedge clock);
    rst <= 1'h0;
    repeat (6) @(posedge clock);
    `CHK("active", 1'h1, act)
    `CHK("io_offset", 10'h078, alloc.io_offset)
    `CHK("io_count", 5'h0A, alloc.io_count)
    `CHK("words", 12'h442, {alloc.in_words, alloc.out_words, alloc.stat_words})
    `CHK("dm", 21'h04B0 << 7 | 21'h64, {alloc.dm_offset, alloc.dm_count})
    `CHK("node_enable", 32'h00FF_00FF, node_en)
    `CHK("cfg", 4'h0, cfg)
    span(1'h0, 200);
    span(1'h1, 53);
    `CHK("link", 1'h1, lok)
    xfer(1'h0, 8'h20, 32'h0);
    `CHK("unmapped", 2'h2, resp)
    pulse_fault();
    `CHK("active", 1'h1, act)
    xfer(1'h1, 8'h0C, 32'h1F);
    `CHK("irq", 1'h1, irq)
    xfer(1'h1, 8'h08, 32'h1F);
    `CHK("irq", 1'h0, irq)
    $display("test narrow done");
    @(posedge clock);
    sw <= 4'hF;
    tens <= 4'h4;
    ones <= 4'h7;
    repeat (3) @(posedge clock);
    `CHK("cfg", 4'h0, cfg)
    xfer(1'h1, 8'h10, 32'h0003_0004);
    `CHK("table write", 2'h0, resp)
    restart();
    `CHK("cfg", 4'hF, cfg)
    `CHK("io", 15'h51D6, {alloc.io_count, alloc.io_offset})
    `CHK("words", 12'h884, {alloc.in_words, alloc.out_words, alloc.stat_words})
    `CHK("dm", 21'h125C << 7 | 21'h64, {alloc.dm_offset, alloc.dm_count})
    `CHK("node_enable", 32'hFFFF_FFFF, node_en)
    span(1'h0, 2400);
    span(1'h1, 426);
    xfer(1'h0, 8'h14, 32'h0);
    `CHK("joined", 32'h0003_0004, rd)
    xfer(1'h0, 8'h08, 32'h0);
    `CHK("reg flags", 2'h1, rd[3:2])
    pulse_fault();
    `CHK("active", 1'h0, act)
    repeat (300) @(posedge clock);
    `CHK("active", 1'h0, act)
    restart();
    `CHK("active", 1'h1, act)
    $display("test wide done");
    @(posedge clock);
    tens <= 4'h9;
    ones <= 4'h5;
    restart();
    `CHK("active", 1'h0, act)
    xfer(1'h0, 8'h08, 32'h0);
    `CHK("cfg error", 1'h1, rd[4])
    ones <= 4'h4;
    restart();
    `CHK("active", 1'h1, act)
    ovl <= 1'h1;
    restart();
    `CHK("active", 1'h0, act)
    $display("test range done");
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: testbench/rimc_slave_chain.sv */
// Purpose: Behavioural chain of remote slaves on the field bus.
// Assumes: Errors are raised only on request from the bench.
// Notes: Fixed population; node 0 is present but unregistered.
`timescale 1ns/1ps
`default_nettype none
module rimc_slave_chain (
  // Bench request
  input wire logic fault_req,
  // Bus status seen by the master
  output logic link_ok_indicator_error,
  output logic [31:0] slave_present
);
  // A mismatched slave is simply absent; the rest answer normally
  assign slave_present = 32'h0003_0005;
  assign link_ok_indicator_error = fault_req;
endmodule
`default_nettype wire
